//--- hw/vsps_defines.svh
// Constants for the start-up and phase sequencer
`ifndef VSPS_DEFINES_SVH
`define VSPS_DEFINES_SVH
`define VSPS_CLK_MHZ        200
`define VSPS_US_CYC         (`VSPS_CLK_MHZ)
`define VSPS_SP_W           10
`define VSPS_LSB_UV         2500
`define VSPS_VID_TOP_CODE   10'h258
`define VSPS_VID_STEP_CODE  10'h005
`define VSPS_BOOT_CODE      10'h1B8
`define VSPS_RATE_SOFT_UV   2500
`define VSPS_RATE_SLEW_UV   5000
`define VSPS_STEP_SOFT      3'(`VSPS_RATE_SOFT_UV / `VSPS_LSB_UV)
`define VSPS_STEP_SLEW      3'(`VSPS_RATE_SLEW_UV / `VSPS_LSB_UV)
`define VSPS_STEP_FAST      3'(2 * `VSPS_RATE_SLEW_UV / `VSPS_LSB_UV)
`define VSPS_WIN_DIV        14'h00A
`define VSPS_WIN_CYCLES     4'hD
`define VSPS_POWER_GOOD_FLAG_US       7000
`define VSPS_TIED_US        120
`endif

//--- hw/vsps_phase.sv
// Master clock one-shot, phase sequencer, slaves, diode emulation
`timescale 1ns/10ps
module vsps_phase (
   input  wire logic       i_clk,           // System clock
   input  wire logic       i_rst_b,         // Sync reset, active low
   input  wire logic       i_en,            // Modulator running
   input  wire logic       i_ramp_at_comp,  // Sawtooth reached comp level
   input  wire logic       i_two_phase,     // Two-phase mode
   input  wire logic [1:0] i_slave_at_win,  // Slave ripple reached window level
   input  wire logic       i_de_mode,       // Diode emulation enabled
   input  wire logic [1:0] i_sw_zero,       // Switch node reached zero
   output logic            o_master_clock,  // One-shot master pulse
   output logic [1:0]      o_phase_clock,   // Per-phase clocks
   output logic [1:0]      o_pwm,           // Slave PWM outputs
   output logic [1:0]      o_low_gate       // Low-side gate drives
);
   logic       cmp_q;      // Last comparator level
   logic       next_cmp_q;
   logic       sel_two;    // Next pulse goes to phase two
   logic       next_sel_two;
   logic [1:0] cut;        // Low side cut off until next set
   logic [1:0] next_cut;
   logic [1:0] next_pwm;
   logic [1:0] next_lg;
   logic [1:0] next_pc;
   logic       next_mc;
   // Master edge and phase routing
   always_comb begin
      next_cmp_q = i_ramp_at_comp;
      next_mc = i_en && i_ramp_at_comp && !cmp_q;
      next_sel_two = sel_two;
      next_pc = 2'h0;
      if (!i_two_phase) begin
         next_sel_two = 1'b0;
         next_pc[0] = next_mc;
      end else if (next_mc) begin
         next_pc[0] = !sel_two;
         next_pc[1] = sel_two;
         next_sel_two = !sel_two;
      end
   end
   // Slaves: set on clock, clear at window, cut low gate at zero
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_slave
         always_comb begin
            next_pwm[k] = o_pwm[k];
            next_cut[k] = cut[k];
            if (next_pc[k]) begin
               next_pwm[k] = 1'b1;
               next_cut[k] = 1'b0;
            end else if (i_slave_at_win[k]) begin
               next_pwm[k] = 1'b0;
            end
            if (!next_pwm[k] && i_de_mode && i_sw_zero[k] && o_low_gate[k]) begin
               next_cut[k] = 1'b1;
            end
            next_lg[k] = i_en && !next_pwm[k] && !next_cut[k];
         end
      end
   endgenerate
   // Register only
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cmp_q <= 1'b0;
         sel_two <= 1'b0;
         cut <= 2'h0;
         o_pwm <= 2'h0;
         o_low_gate <= 2'h0;
         o_phase_clock <= 2'h0;
         o_master_clock <= 1'b0;
      end else begin
         cmp_q <= next_cmp_q;
         sel_two <= next_sel_two;
         cut <= next_cut;
         o_pwm <= next_pwm;
         o_low_gate <= next_lg;
         o_phase_clock <= next_pc;
         o_master_clock <= next_mc;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   logic last_one; // Helper: previous routed pulse was phase one
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || !i_two_phase) last_one <= 1'b0;
      else if (o_phase_clock[0]) last_one <= 1'b1;
      else if (o_phase_clock[1]) last_one <= 1'b0;
   end
   property p_alternate;
      (i_two_phase && $past(i_two_phase) && o_phase_clock[1]) |-> last_one;
   endproperty
   a_alternate: assert property (p_alternate) else $error("phase two clock without phase one");
   property p_single;
      (!i_two_phase && $past(!i_two_phase)) |-> !o_phase_clock[1] && o_phase_clock[0] == o_master_clock;
   endproperty
   a_single: assert property (p_single) else $error("single phase routing wrong");
   property p_de_cut;
      (i_de_mode && o_low_gate[0] && i_sw_zero[0] && !next_pc[0]) |=> !o_low_gate[0];
   endproperty
   a_de_cut: assert property (p_de_cut) else $error("low gate not cut at zero");
   c_two_phase: cover property (i_two_phase && o_phase_clock[1]);
endmodule

//--- hw/vsps_pkg.sv
// Types shared by the sequencer modules
package vsps_pkg;
   typedef enum logic [3:0] {
      VSPS_IDLE  = 4'h1,
      VSPS_DELAY = 4'h2,
      VSPS_RAMP  = 4'h4,
      VSPS_RUN   = 4'h8
   } vsps_state_t;
endpackage

//--- hw/vsps_ramp.sv
// Setpoint slewer stepping once per microsecond
`timescale 1ns/10ps
`include "vsps_defines.svh"
module vsps_ramp (
   input  wire logic   i_clk,   // System clock
   input  wire logic   i_rst_b, // Sync reset, active low
   vsps_ramp_if.ramp   lnk      // Control link
);
   localparam int UC = `VSPS_US_CYC;
   logic [7:0]            us_cnt;       // Microsecond divider
   logic [7:0]            next_us_cnt;
   logic                  tick;         // One-cycle microsecond enable
   logic [`VSPS_SP_W-1:0] sp;           // Setpoint register
   logic [`VSPS_SP_W-1:0] next_sp;
   generate
      if (UC < 2 || UC > 256) begin : g_chk
         $error("divider out of range");
      end
   endgenerate
   assign tick = (us_cnt == 8'(UC - 1));
   assign lnk.setpoint = sp;
   assign lnk.at_target = (sp == lnk.target);
   // Next divider and setpoint; moves by step, never overshoots
   always_comb begin
      next_us_cnt = tick ? 8'h00 : us_cnt + 8'h01;
      next_sp = sp;
      if (!lnk.run) begin
         next_sp = '0; // Idle discharges setpoint
         next_us_cnt = 8'h00;
      end else if (tick) begin
         if (lnk.target > sp) begin
            next_sp = (lnk.target - sp > `VSPS_SP_W'(lnk.step)) ? sp + `VSPS_SP_W'(lnk.step) : lnk.target;
         end else if (lnk.target < sp) begin
            next_sp = (sp - lnk.target > `VSPS_SP_W'(lnk.step)) ? sp - `VSPS_SP_W'(lnk.step) : lnk.target;
         end
      end
   end
   // Register only
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         us_cnt <= 8'h00;
         sp <= '0;
      end else begin
         us_cnt <= next_us_cnt;
         sp <= next_sp;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_slew_step;
      (lnk.run && $past(lnk.run) && sp != $past(sp)) |->
         ($past(tick) && (sp > $past(sp) ? sp - $past(sp) : $past(sp) - sp) <= `VSPS_SP_W'($past(lnk.step)));
   endproperty
   a_slew_step: assert property (p_slew_step) else $error("setpoint moved too far or off tick");
   property p_idle_zero;
      !lnk.run |=> sp == '0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("setpoint not cleared when idle");
endmodule

//--- hw/vsps_ramp_if.sv
// Link between sequencer control and setpoint ramp
`timescale 1ns/10ps
`include "vsps_defines.svh"
interface vsps_ramp_if;
   logic [`VSPS_SP_W-1:0] target;    // Level to ramp to
   logic [2:0]            step;      // Codes per microsecond
   logic                  run;       // Ramp active, else zero
   logic [`VSPS_SP_W-1:0] setpoint;  // Present setpoint
   logic                  at_target; // Setpoint equals target
   modport ctl  (output target, step, run, input setpoint, at_target);
   modport ramp (input target, step, run, output setpoint, at_target);
endinterface

//--- hw/vsps_top.sv
// Start-up sequencer top: enable, soft-start, window count, outputs
`timescale 1ns/10ps
`include "vsps_defines.svh"
// Functional notes
// - Start only with supply good and enable
// - Processor mode soft-starts to 1.1V boot
// - 13 in-window cycles: clock enable, slew
// - Power good about 7ms after start
// - Tied enable: start 120us after supply
// - Graphics ramps to target; sleep doubles rate
// - Graphics: clock enable after 13 cycles
// - Two-phase: pulses alternate between phases
// - Single-phase: phase one only
// - Master one-shot when ramp meets comp
// - Slave sets on clock, clears at window
// - Diode emulation cuts low gate at zero
// - Code zero is 1.5V, 12.5mV per step
module vsps_top #(
   parameter int POWER_GOOD_FLAG_CYC = `VSPS_POWER_GOOD_FLAG_US * `VSPS_CLK_MHZ, // Start to power good
   parameter int TIED_CYC  = `VSPS_TIED_US * `VSPS_CLK_MHZ   // Tied-enable delay
) (
   input  wire logic                  i_clk,                  // 200 MHz clock
   input  wire logic                  i_rst_b,                // Sync reset, active low
   input  wire logic                  i_supply_por_ok,        // Supply above POR level
   input  wire logic                  i_regulator_on_request, // Enable request
   input  wire logic                  i_gpu_mode,             // Graphics configuration
   input  wire logic                  i_deeper_sleep_select,  // Doubles graphics rate
   input  wire logic [6:0]            i_voltage_id_code,      // Target code
   input  wire logic [`VSPS_SP_W-1:0] i_vout_code,            // Measured output, setpoint units
   input  wire logic                  i_ramp_at_comp,         // Sawtooth reached comp
   input  wire logic                  i_two_phase,            // Two-phase mode
   input  wire logic [1:0]            i_slave_at_window,      // Slave ripple at window
   input  wire logic                  i_diode_emulation_mode, // Diode emulation mode
   input  wire logic [1:0]            i_switch_node_zero,     // Switch node at zero
   output logic [`VSPS_SP_W-1:0]      o_setpoint,             // Internal setpoint
   output logic                       o_clk_en_b,             // Clock enable, active low
   output logic                       o_power_good_flag,      // Power good
   output logic                       o_master_clock,         // Master one-shot
   output logic                       o_phase_one_clock,      // Phase one clock
   output logic                       o_phase_two_clock,      // Phase two clock
   output logic [1:0]                 o_pwm,                  // Slave PWM
   output logic [1:0]                 o_low_side_gate         // Low-side gates
);
   // Counter widths follow the timer limits
   localparam int PW = $clog2(POWER_GOOD_FLAG_CYC + 1);
   localparam int TW = $clog2(TIED_CYC + 1);

   // A zero timer would leave the counters without an end
   generate
      if (POWER_GOOD_FLAG_CYC < 1 || TIED_CYC < 1) begin : g_chk
         $error("timer counts must be positive");
      end
   endgenerate

   // Sequencer state, timers and window terms
   vsps_ramp_if lnk ();              // Ramp link
   vsps_pkg::vsps_state_t state;     // Sequencer state
   vsps_pkg::vsps_state_t next_state;
   logic                  fresh;     // Enable already high at supply rise
   logic                  next_fresh;
   logic [TW-1:0]         dly_cnt;   // Tied-enable delay counter
   logic [TW-1:0]         next_dly_cnt;
   logic [PW-1:0]         pg_cnt;    // Start-to-power-good counter
   logic [PW-1:0]         next_pg_cnt;
   logic [3:0]            win_cnt;   // Consecutive in-window cycles
   logic [3:0]            next_win_cnt;
   logic                  next_clk_en_b;
   logic                  next_pg;

   logic                  enabled;   // Supply good and request high
   logic [`VSPS_SP_W-1:0] vid_lvl;   // Decoded target
   logic [`VSPS_SP_W-1:0] tgt;       // Level for ramp and window
   logic [`VSPS_SP_W-1:0] diff;      // Distance of output from level
   logic                  in_win;    // Output within 10 percent
   logic [1:0]            pclk;      // Phase clocks

   // Codes past the zero level wrap; the host never sends them
   // Target decode: top code minus a step per count
   assign vid_lvl = `VSPS_VID_TOP_CODE - `VSPS_SP_W'(i_voltage_id_code) * `VSPS_VID_STEP_CODE;
   assign enabled = i_supply_por_ok && i_regulator_on_request;

   // Ramp target and rate by configuration and phase of start-up
   always_comb begin
      lnk.run = (state == vsps_pkg::VSPS_RAMP) || (state == vsps_pkg::VSPS_RUN);
      if (i_gpu_mode) begin
         // Graphics: straight to the coded level
         tgt = vid_lvl;
         lnk.step = i_deeper_sleep_select ? `VSPS_STEP_FAST : `VSPS_STEP_SLEW;
      end else if (state == vsps_pkg::VSPS_RUN) begin
         // Processor: boot level first, then the coded level
         tgt = vid_lvl;
         lnk.step = `VSPS_STEP_SLEW;
      end else begin
         tgt = `VSPS_BOOT_CODE;
         lnk.step = `VSPS_STEP_SOFT;
      end
      // Window and ramp share one level
      lnk.target = tgt;
   end

   // Window test; product kept wide so it cannot wrap
   // Exactly 10 percent off still counts as inside
   always_comb begin
      diff = (i_vout_code >= tgt) ? i_vout_code - tgt : tgt - i_vout_code;
      in_win = (14'(diff) * `VSPS_WIN_DIV) <= 14'(tgt);
   end

   // Sequencer next state and counters
   always_comb begin
      // Hold everything unless a branch moves it
      next_state = state;
      next_fresh = fresh;
      next_dly_cnt = dly_cnt;
      next_pg_cnt = pg_cnt;
      next_win_cnt = win_cnt;
      next_clk_en_b = o_clk_en_b;
      next_pg = o_power_good_flag;

      if (!i_supply_por_ok) begin
         next_fresh = 1'b1; // Rearm tied detection on supply loss
      end

      unique case (state)
         // Waiting: timers clear, outputs released
         vsps_pkg::VSPS_IDLE: begin
            next_dly_cnt = '0;
            next_pg_cnt = '0;
            next_win_cnt = 4'h0;
            next_clk_en_b = 1'b1;
            next_pg = 1'b0;
            // Supply present: a later request is not tied
            if (i_supply_por_ok) begin
               next_fresh = 1'b0;
            end
            // Request with supply: a tied start waits first
            if (enabled) begin
               next_state = fresh ? vsps_pkg::VSPS_DELAY : vsps_pkg::VSPS_RAMP;
            end
         end

         // Tied request: hold off the ramp
         vsps_pkg::VSPS_DELAY: begin
            next_dly_cnt = dly_cnt + TW'(1);
            next_pg_cnt = pg_cnt + PW'(1);
            // Power-good timer already runs here
            if (dly_cnt == TW'(TIED_CYC - 1)) begin
               next_state = vsps_pkg::VSPS_RAMP;
            end
         end

         // Soft-start: count in-window master pulses
         vsps_pkg::VSPS_RAMP: begin
            if (pg_cnt != PW'(POWER_GOOD_FLAG_CYC)) begin
               next_pg_cnt = pg_cnt + PW'(1);
            end
            // Any miss restarts the run of cycles
            if (!in_win) begin
               next_win_cnt = 4'h0;
            end else if (o_master_clock) begin
               next_win_cnt = win_cnt + 4'h1;
            end
            // Thirteenth pulse counted: release the clocks
            if (win_cnt == `VSPS_WIN_CYCLES) begin
               next_clk_en_b = 1'b0;
               next_state = vsps_pkg::VSPS_RUN;
            end
         end

         // Regulating: timer saturates, flag follows
         vsps_pkg::VSPS_RUN: begin
            if (pg_cnt != PW'(POWER_GOOD_FLAG_CYC)) begin
               next_pg_cnt = pg_cnt + PW'(1);
            end else begin
               next_pg = 1'b1;
            end
         end
      endcase

      // Loss of either term ends start-up; the ramp then discharges
      if (!enabled && state != vsps_pkg::VSPS_IDLE) begin
         next_state = vsps_pkg::VSPS_IDLE; // drop of enable aborts
         next_clk_en_b = 1'b1;
         next_pg = 1'b0;
      end
   end

   // Register only
   // Reset releases clock enable and drops power good
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state <= vsps_pkg::VSPS_IDLE;
         fresh <= 1'b1;
         dly_cnt <= '0;
         pg_cnt <= '0;
         win_cnt <= 4'h0;
         o_clk_en_b <= 1'b1;
         o_power_good_flag <= 1'b0;
      end else begin
         state <= next_state;
         fresh <= next_fresh;
         dly_cnt <= next_dly_cnt;
         pg_cnt <= next_pg_cnt;
         win_cnt <= next_win_cnt;
         o_clk_en_b <= next_clk_en_b;
         o_power_good_flag <= next_pg;
      end
   end

   // Setpoint slewer
   vsps_ramp u_ramp (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .lnk     (lnk)
   );
   assign o_setpoint = lnk.setpoint;

   // Modulator digital part runs once soft-start is under way
   vsps_phase u_phase (
      .i_clk          (i_clk),
      .i_rst_b        (i_rst_b),
      .i_en           (lnk.run),
      .i_ramp_at_comp (i_ramp_at_comp),
      .i_two_phase    (i_two_phase),
      .i_slave_at_win (i_slave_at_window),
      .i_de_mode      (i_diode_emulation_mode),
      .i_sw_zero      (i_switch_node_zero),
      .o_master_clock (o_master_clock),
      .o_phase_clock  (pclk),
      .o_pwm          (o_pwm),
      .o_low_gate     (o_low_side_gate)
   );
   // Phase clocks leave the top as two pins
   assign o_phase_one_clock = pclk[0];
   assign o_phase_two_clock = pclk[1];

   // Assertions share the system clock and rest during reset
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   // Clock enable falls only from soft-start after 13 pulses
   property p_clk_en_count;
      $fell(o_clk_en_b) |-> $past(win_cnt) == `VSPS_WIN_CYCLES && $past(state) == vsps_pkg::VSPS_RAMP;
   endproperty
   a_clk_en_count: assert property (p_clk_en_count) else $error("clock enable without 13 cycles");

   // Power good rises only on a full timer with clocks enabled
   property p_power_good_flag_time;
      $rose(o_power_good_flag) |-> !o_clk_en_b && $past(pg_cnt) == PW'(POWER_GOOD_FLAG_CYC);
   endproperty
   a_power_good_flag_time: assert property (p_power_good_flag_time) else $error("power good at wrong time");

   // A full timer in regulation raises power good next edge
   property p_power_good_flag_due;
      (state == vsps_pkg::VSPS_RUN && pg_cnt == PW'(POWER_GOOD_FLAG_CYC) && enabled) |=> o_power_good_flag;
   endproperty
   a_power_good_flag_due: assert property (p_power_good_flag_due) else $error("power good late");

   // Before start both outputs stay released
   property p_idle_hold;
      (state == vsps_pkg::VSPS_IDLE) |=> o_clk_en_b && !o_power_good_flag;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("outputs not held before start");

   // Clock enable and power good are given only in regulation
   property p_out_run;
      (!o_clk_en_b || o_power_good_flag) |-> state == vsps_pkg::VSPS_RUN;
   endproperty
   a_out_run: assert property (p_out_run) else $error("outputs given before start-up ended");

   // An out-of-window cycle restarts the count
   property p_win_restart;
      (state == vsps_pkg::VSPS_RAMP && !in_win && enabled) |=> win_cnt == 4'h0;
   endproperty
   a_win_restart: assert property (p_win_restart) else $error("window count not restarted");

   // No start without both enable terms
   property p_no_start;
      (state == vsps_pkg::VSPS_IDLE && !enabled) |=> state == vsps_pkg::VSPS_IDLE;
   endproperty
   a_no_start: assert property (p_no_start) else $error("start without enable");

   // Losing either term ends start-up at the next edge
   property p_abort;
      (!enabled && state != vsps_pkg::VSPS_IDLE) |=> state == vsps_pkg::VSPS_IDLE && o_clk_en_b && !o_power_good_flag;
   endproperty
   a_abort: assert property (p_abort) else $error("start-up not ended on enable loss");

   // A request after supply is good skips the tied delay
   property p_late_start;
      (state == vsps_pkg::VSPS_IDLE && enabled && !fresh) |=> state == vsps_pkg::VSPS_RAMP;
   endproperty
   a_late_start: assert property (p_late_start) else $error("late request did not ramp");

   // A tied request waits out the whole delay
   property p_tied_wait;
      (state == vsps_pkg::VSPS_DELAY && enabled && dly_cnt != TW'(TIED_CYC - 1)) |=> state == vsps_pkg::VSPS_DELAY;
   endproperty
   a_tied_wait: assert property (p_tied_wait) else $error("tied delay cut short");

   // Main start-up scenarios
   c_clk_en: cover property ($fell(o_clk_en_b));
   c_power_good_flag: cover property ($rose(o_power_good_flag));
   c_tied: cover property (state == vsps_pkg::VSPS_DELAY ##1 state == vsps_pkg::VSPS_RAMP);
endmodule

//--- testbench/vsps_plant.sv
// Plant model: output level, slave ripple compares, switch nodes
`timescale 1ns/10ps
`include "vsps_defines.svh"
module vsps_plant (
   input  wire logic                  i_clk,       // System clock
   input  wire logic                  i_hold,      // Force output level
   input  wire logic [`VSPS_SP_W-1:0] i_hold_code, // Forced level
   input  wire logic [`VSPS_SP_W-1:0] i_setpoint,  // Regulator setpoint
   input  wire logic [1:0]            i_pwm,       // Slave PWM
   input  wire logic [1:0]            i_low_gate,  // Low-side gates
   output logic [`VSPS_SP_W-1:0]      o_vout,      // Measured output
   output logic [1:0]                 o_at_win,    // Ripple at window
   output logic [1:0]                 o_sw_zero    // Switch node at zero
);
   logic [2:0] on_cnt [2] = '{3'h0, 3'h0}; // Cycles PWM high
   logic [2:0] lg_cnt [2] = '{3'h0, 3'h0}; // Cycles gate high
   // Ideal loop follows setpoint; forcing lets the bench leave the window
   assign o_vout = i_hold ? i_hold_code : i_setpoint;
   // Ripple and phase-node timers, saturating
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < 2; k++) begin
         on_cnt[k] <= !i_pwm[k] ? 3'h0 : (on_cnt[k] == 3'h7) ? on_cnt[k] : on_cnt[k] + 3'h1;
         lg_cnt[k] <= !i_low_gate[k] ? 3'h0 : (lg_cnt[k] == 3'h7) ? lg_cnt[k] : lg_cnt[k] + 3'h1;
      end
   end
   // Ripple reaches window after three on cycles
   assign o_at_win  = {on_cnt[1] >= 3'h3, on_cnt[0] >= 3'h3};
   // Inductor current runs dry two cycles into the low side
   assign o_sw_zero = {lg_cnt[1] >= 3'h2, lg_cnt[0] >= 3'h2};
endmodule

//--- testbench/vsps_top_tb.sv
// Bench for the start-up and phase sequencer
`timescale 1ns/10ps
`include "vsps_defines.svh"
module vsps_top_tb;
   localparam int PG_CYC = 4000; // Shortened power-good time
   localparam int TD_CYC = 50;   // Shortened tied delay
   logic       clk = 1'b0, rst_b = 1'b0;      // Clock, reset
   logic       por = 1'b0, req = 1'b0;        // Enable terms
   logic       gpu = 1'b0, slp = 1'b0;        // Mode, rate doubler
   logic [6:0] code = 7'h00;                  // Target code
   logic       cmp = 1'b0, two = 1'b0;        // Sawtooth, phases
   logic       diode = 1'b0, hold = 1'b0;     // Emulation, forcing
   logic [9:0] hold_code = 10'h000, s0;       // Forced level, sample
   logic [9:0] vout, setpoint;                // Output level
   logic [1:0] at_win, sw_zero, pwm, lg, pwm_q = 2'h0;
   logic       clk_en_b, pg, mclk, p1, p2;    // Status and pulses
   int cyc = 0, nm = 0, n1 = 0, n2 = 0, r0 = 0, r1 = 0;
   int n_fail = 0, checks_done = 0, d, t0, a1, a2, am, b0, b1;
   always #2.5 clk = ~clk;
   vsps_top #(.POWER_GOOD_FLAG_CYC(PG_CYC), .TIED_CYC(TD_CYC)) dut_u (
      .i_clk(clk), .i_rst_b(rst_b), .i_supply_por_ok(por),
      .i_regulator_on_request(req), .i_gpu_mode(gpu),
      .i_deeper_sleep_select(slp), .i_voltage_id_code(code),
      .i_vout_code(vout), .i_ramp_at_comp(cmp), .i_two_phase(two),
      .i_slave_at_window(at_win), .i_diode_emulation_mode(diode),
      .i_switch_node_zero(sw_zero), .o_setpoint(setpoint),
      .o_clk_en_b(clk_en_b), .o_power_good_flag(pg),
      .o_master_clock(mclk), .o_phase_one_clock(p1),
      .o_phase_two_clock(p2), .o_pwm(pwm), .o_low_side_gate(lg));
   vsps_plant plant_u (
      .i_clk(clk), .i_hold(hold), .i_hold_code(hold_code),
      .i_setpoint(setpoint), .i_pwm(pwm), .i_low_gate(lg),
      .o_vout(vout), .o_at_win(at_win), .o_sw_zero(sw_zero));
   // Pulse and edge tallies, sampled at each edge
   always @(posedge clk) begin
      cyc <= cyc + 1;
      nm <= nm + int'(mclk === 1'b1);
      n1 <= n1 + int'(p1 === 1'b1);
      n2 <= n2 + int'(p2 === 1'b1);
      r0 <= r0 + int'(pwm[0] === 1'b1 && pwm_q[0] === 1'b0);
      r1 <= r1 + int'(pwm[1] === 1'b1 && pwm_q[1] === 1'b0);
      pwm_q <= pwm;
   end
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare and tally
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Step edges, landing just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Sawtooth meets comp n times, ten cycles apart
   task automatic comp(input int n);
      repeat (n) begin
         cmp = 1'b1;
         tick(1);
         cmp = 1'b0;
         tick(9);
      end
   endtask
   // Cycles until the setpoint moves, bounded
   task automatic wait_move(input int lim, output int n);
      logic [9:0] s;
      s = setpoint;
      n = 0;
      while (setpoint === s && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         finish_test();
      end
   endtask
   // Count check over four pulses in each phase and emulation mode
   task automatic mod_check(input logic tw, input logic de);
      two = tw;
      diode = de;
      a1 = n1;
      a2 = n2;
      am = nm;
      b0 = r0;
      b1 = r1;
      comp(4);
      chk(nm - am, 16'h0004);
      chk(n1 - a1, tw ? 16'h0002 : 16'h0004);
      chk(n2 - a2, tw ? 16'h0002 : 16'h0000);
      chk(r0 - b0, n1 - a1);
      chk(r1 - b1, n2 - a2);
      chk(pwm, 16'h0000);
      chk(lg[0], !de);
      chk(lg[1], !de);
   endtask
   // Main sequence
   initial begin
      tick(2);
      rst_b = 1'b1;
      chk(setpoint, 16'h0000);
      chk({pg, clk_en_b}, 16'h0001);
      // Supply good but no request: nothing moves
      por = 1'b1;
      comp(2);
      chk(nm, 16'h0000);
      chk(setpoint, 16'h0000);
      // Processor start with output held at boot level
      hold = 1'b1;
      hold_code = 10'h1B8;
      req = 1'b1;
      t0 = cyc;
      wait_move(400, d);
      chk(d >= 198 && d <= 205, 16'h0001);
      s0 = setpoint;
      tick(1000);
      chk(setpoint, s0 + 10'h005);
      // Leaving the window restarts the count
      comp(12);
      hold_code = 10'h000;
      tick(3);
      hold_code = 10'h1B8;
      comp(12);
      chk({pg, clk_en_b}, 16'h0001);
      comp(1);
      chk(clk_en_b, 16'h0000);
      s0 = setpoint;
      tick(1000);
      chk(setpoint, s0 + 10'h00A);
      for (int m = 0; m < 4; m++)
         mod_check(m[0], m[1]);
      d = 0;
      while (pg !== 1'b1 && d < PG_CYC) begin
         tick(1);
         d++;
      end
      if (d >= PG_CYC) begin
         n_fail++;
         finish_test();
      end
      chk(cyc - t0 >= PG_CYC && cyc - t0 <= PG_CYC + 4, 16'h0001);
      req = 1'b0;
      tick(3);
      chk({setpoint, pg, clk_en_b}, 16'h0001);
      // Graphics start at both rates, output held at the target
      gpu = 1'b1;
      hold_code = 10'h258;
      for (int k = 0; k < 2; k++) begin
         slp = k[0];
         req = 1'b1;
         wait_move(400, d);
         s0 = setpoint;
         tick(1000);
         chk(setpoint, s0 + (k ? 10'h014 : 10'h00A));
         comp(12);
         chk(clk_en_b, 16'h0001);
         comp(1);
         chk(clk_en_b, 16'h0000);
         req = 1'b0;
         tick(3);
      end
      // Low target reached and held
      hold = 1'b0;
      code = 7'h74;
      req = 1'b1;
      tick(2400);
      chk(setpoint, 10'h258 - 10'h005 * 10'h074);
      req = 1'b0;
      // Tied request: supply rises with request already high
      gpu = 1'b0;
      por = 1'b0;
      tick(2);
      req = 1'b1;
      tick(300);
      chk(setpoint, 16'h0000);
      por = 1'b1;
      wait_move(800, d);
      chk(d >= TD_CYC + 198 && d <= TD_CYC + 205, 16'h0001);
      finish_test();
   end
endmodule
